// File: pkg/freq_ref_pkg.sv
// register constants for the frequency reference selector
// assumes a 100 MHz system clock and an AXI4-Lite master
package freq_ref_pkg;
    localparam int CLK_NS          = 10;
    localparam int TICK_NS         = 100_000_000;
    localparam int TICK_CYCLES     = TICK_NS / CLK_NS;
    localparam int FW              = 12;
    localparam int TW              = 13;
    localparam logic [FW-1:0] FREQ_MAX     = 12'hFA0;
    localparam logic [TW-1:0] TIME_MIN     = 13'h0001;
    localparam logic [TW-1:0] TIME_MAX     = 13'h1770;
    localparam logic [9:0]    DCB_CONT     = 10'h3E7;
    localparam logic [2:0] SEL_INTERNAL    = 3'h1;
    localparam logic [2:0] SEL_PRESET_LOW  = 3'h4;
    localparam logic [4:0] FN_PRESET       = 5'h04;
    localparam logic [4:0] FN_RAISE        = 5'h10;
    localparam logic [4:0] FN_LOWER        = 5'h11;
    localparam logic [4:0] FN_JOG          = 5'h02;
    localparam logic [4:0] FN_ALT_RAMP     = 5'h06;
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_DIN_FUNC    = 8'h04;
    localparam logic [7:0] OFS_INT_FREQ    = 8'h08;
    localparam logic [7:0] OFS_STORED      = 8'h0C;
    localparam logic [7:0] OFS_PRESET0     = 8'h10;
    localparam logic [7:0] OFS_PRESET7     = 8'h2C;
    localparam logic [7:0] OFS_JOG_FREQ    = 8'h30;
    localparam logic [7:0] OFS_JOG_RAMP    = 8'h34;
    localparam logic [7:0] OFS_DCB_TIME    = 8'h38;
    localparam logic [7:0] OFS_MAX_FREQ    = 8'h3C;
    localparam logic [7:0] OFS_ACCEL1      = 8'h40;
    localparam logic [7:0] OFS_DECEL1      = 8'h44;
    localparam logic [7:0] OFS_ACCEL2      = 8'h48;
    localparam logic [7:0] OFS_DECEL2      = 8'h4C;
    localparam logic [7:0] OFS_STATUS      = 8'h50;
    localparam logic [FW-1:0] RST_INT_FREQ = 12'h258;
    localparam logic [FW-1:0] RST_JOG_FREQ = 12'h064;
    localparam logic [TW-1:0] RST_JOG_RAMP = 13'h0064;
    localparam logic [TW-1:0] RST_RAMP1    = 13'h0064;
    localparam logic [TW-1:0] RST_RAMP2    = 13'h00C8;
    localparam logic [FW-1:0] RST_MAX_FREQ = 12'h258;
    localparam logic [2:0]    RST_SEL      = 3'h1;
    localparam logic [FW-1:0] RST_PRESET [8] = '{12'h000, 12'h032, 12'h064, 12'h0C8,
                                                 12'h12C, 12'h190, 12'h1F4, 12'h258};
    localparam logic [1:0] SRC_EXT         = 2'h0;
    localparam logic [1:0] SRC_INTERNAL    = 2'h1;
    localparam logic [1:0] SRC_PRESET      = 2'h2;
    localparam logic [1:0] SRC_JOG         = 2'h3;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage

// File: src/frequency_reference_selector.sv
// frequency command and ramp time selection for a motor drive
// assumes keypad, input terminals and brake request are asynchronous pins
`timescale 1ns/100ps
module frequency_reference_selector #(
    parameter int TICK_CYCLES = freq_ref_pkg::TICK_CYCLES
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic [7:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [7:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [3:0]                  digitalIn,
    input  wire logic                        keyUp,
    input  wire logic                        keyDown,
    input  wire logic                        keyEnter,
    input  wire logic                        keyEsc,
    input  wire logic                        programMode,
    input  wire logic                        dcBrakeReq,
    input  wire logic [freq_ref_pkg::FW-1:0] extFreqRef,
    output logic [freq_ref_pkg::FW-1:0]      freqCommand,
    output logic [freq_ref_pkg::TW-1:0]      accelTime,
    output logic [freq_ref_pkg::TW-1:0]      decelTime,
    output logic                             jogActive,
    output logic                             eepromWrite,
    output logic [freq_ref_pkg::FW-1:0]      eepromData,
    output logic                             dcBrakeActive
);
    import freq_ref_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [FW-1:0] clampFreq(input logic [31:0] v);
        return (v > 32'(FREQ_MAX)) ? FREQ_MAX : v[FW-1:0];
    endfunction

    function automatic logic [TW-1:0] clampTime(input logic [31:0] v);
        logic [TW-1:0] r;
        r = (v > 32'(TIME_MAX)) ? TIME_MAX : v[TW-1:0];
        return (r < TIME_MIN) ? TIME_MIN : r;
    endfunction

    // pin synchronisers
    logic [9:0] syncA;
    logic [9:0] syncB;
    logic [9:0] syncPrev;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            syncA    <= '0;
            syncB    <= '0;
            syncPrev <= '0;
        end else begin
            syncA    <= {dcBrakeReq, programMode, keyEsc, keyEnter, keyDown, keyUp, digitalIn};
            syncB    <= syncA;
            syncPrev <= syncB;
        end
    end
    logic [3:0] din;
    logic       upPress;
    logic       downPress;
    logic       enterPress;
    logic       escPress;
    logic       progSync;
    logic       brakeReq;
    logic       brakeRise;
    assign din        = syncB[3:0];
    assign upPress    = syncB[4] & ~syncPrev[4];
    assign downPress  = syncB[5] & ~syncPrev[5];
    assign enterPress = syncB[6] & ~syncPrev[6];
    assign escPress   = syncB[7] & ~syncPrev[7];
    assign progSync   = syncB[8];
    assign brakeReq   = syncB[9];
    assign brakeRise  = syncB[9] & ~syncPrev[9];

    // 0.1 s tick
    logic [31:0] tickCount;
    logic        tick;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tickCount <= '0;
            tick      <= 1'b0;
        end else if (tickCount >= 32'(TICK_CYCLES - 1)) begin
            tickCount <= '0;
            tick      <= 1'b1;
        end else begin
            tickCount <= tickCount + 32'd1;
            tick      <= 1'b0;
        end
    end

    // settings
    logic [2:0]    speedRefSel;
    logic [4:0]    dinFunc [4];
    logic [FW-1:0] presetFreq [8];
    logic [FW-1:0] jogFreq;
    logic [TW-1:0] jogRamp;
    logic [9:0]    dcBrakeDuration;
    logic [FW-1:0] maxFreq;
    logic [TW-1:0] accel1;
    logic [TW-1:0] decel1;
    logic [TW-1:0] accel2;
    logic [TW-1:0] decel2;
    logic [FW-1:0] internalFreq;
    logic [FW-1:0] storedFreq;

    // write channel: address and data taken in either order
    logic          awHeld;
    logic          wHeld;
    logic [7:0]    awAddr;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          doWrite;
    logic [31:0]   wordNow;
    logic          hitW;
    assign doWrite = awHeld & wHeld & ~s_axi_bvalid;

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_STATUS);
    endfunction

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= '0;
            wData         <= '0;
            wStrb         <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= ~awHeld & ~(s_axi_awvalid & s_axi_awready) & ~doWrite & ~s_axi_bvalid;
            s_axi_wready  <= ~wHeld & ~(s_axi_wvalid & s_axi_wready) & ~doWrite & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // current contents of the addressed word, for byte-lane merging
    logic [31:0] readWord;
    logic [31:0] statusWord;
    function automatic logic [31:0] regWord(input logic [7:0] a);
        logic [31:0] r;
        r = '0;
        if (a >= OFS_PRESET0 && a <= OFS_PRESET7) begin
            r = 32'(presetFreq[3'(a[7:2] - 6'h04)]);
        end else begin
            case (a)
                OFS_CTRL:     r = 32'(speedRefSel);
                OFS_DIN_FUNC: r = {3'h0, dinFunc[3], 3'h0, dinFunc[2], 3'h0, dinFunc[1], 3'h0, dinFunc[0]};
                OFS_INT_FREQ: r = 32'(internalFreq);
                OFS_STORED:   r = 32'(storedFreq);
                OFS_JOG_FREQ: r = 32'(jogFreq);
                OFS_JOG_RAMP: r = 32'(jogRamp);
                OFS_DCB_TIME: r = 32'(dcBrakeDuration);
                OFS_MAX_FREQ: r = 32'(maxFreq);
                OFS_ACCEL1:   r = 32'(accel1);
                OFS_DECEL1:   r = 32'(decel1);
                OFS_ACCEL2:   r = 32'(accel2);
                OFS_DECEL2:   r = 32'(decel2);
                OFS_STATUS:   r = statusWord;
                default:      r = '0;
            endcase
        end
        return r;
    endfunction
    assign wordNow = merge(regWord(awAddr), wData, wStrb);
    assign hitW    = doWrite & mapped(awAddr);

    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            speedRefSel     <= RST_SEL;
            for (int i = 0; i < 4; i++) begin
                dinFunc[i] <= '0;
            end
            for (int i = 0; i < 8; i++) begin
                presetFreq[i] <= RST_PRESET[i];
            end
            jogFreq         <= RST_JOG_FREQ;
            jogRamp         <= RST_JOG_RAMP;
            dcBrakeDuration <= '0;
            maxFreq         <= RST_MAX_FREQ;
            accel1          <= RST_RAMP1;
            decel1          <= RST_RAMP1;
            accel2          <= RST_RAMP2;
            decel2          <= RST_RAMP2;
        end else if (hitW) begin
            if (awAddr >= OFS_PRESET0 && awAddr <= OFS_PRESET7) begin
                presetFreq[3'(awAddr[7:2] - 6'h04)] <= clampFreq(wordNow);
            end
            case (awAddr)
                OFS_CTRL:     speedRefSel <= wordNow[2:0];
                OFS_DIN_FUNC: begin
                    for (int i = 0; i < 4; i++) begin
                        dinFunc[i] <= wordNow[8*i +: 5];
                    end
                end
                OFS_JOG_FREQ: jogFreq <= clampFreq(wordNow);
                OFS_JOG_RAMP: jogRamp <= clampTime(wordNow);
                OFS_DCB_TIME: dcBrakeDuration <= (wordNow > 32'(DCB_CONT)) ? DCB_CONT : wordNow[9:0];
                OFS_MAX_FREQ: maxFreq <= clampFreq(wordNow);
                OFS_ACCEL1:   accel1 <= clampTime(wordNow);
                OFS_DECEL1:   decel1 <= clampTime(wordNow);
                OFS_ACCEL2:   accel2 <= clampTime(wordNow);
                OFS_DECEL2:   decel2 <= clampTime(wordNow);
                default:      ;
            endcase
        end
    end

    // input function decode
    logic [3:0] fnRaise;
    logic [3:0] fnLower;
    logic [3:0] fnJog;
    logic [3:0] fnAlt;
    logic [2:0] fnPreset;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            fnRaise[i] = (dinFunc[i] == FN_RAISE);
            fnLower[i] = (dinFunc[i] == FN_LOWER);
            fnJog[i]   = (dinFunc[i] == FN_JOG);
            fnAlt[i]   = (dinFunc[i] == FN_ALT_RAMP);
        end
        for (int i = 0; i < 3; i++) begin
            fnPreset[i] = (dinFunc[i] == FN_PRESET);
        end
    end
    logic       mopConfigured;
    logic       raiseOn;
    logic       lowerOn;
    logic [2:0] presetIdx;
    logic       presetOn;
    logic       jogOn;
    logic       altRampOn;
    assign mopConfigured = |(fnRaise | fnLower);
    assign raiseOn       = |(fnRaise & din);
    assign lowerOn       = |(fnLower & din);
    assign presetIdx     = fnPreset & din[2:0];
    assign presetOn      = |presetIdx;
    assign jogOn         = |(fnJog & din);
    assign altRampOn     = |(fnAlt & din);

    // internal frequency: keypad, remote raise/lower, commit and discard
    logic adjustEnabled;
    assign adjustEnabled = progSync && (speedRefSel == SEL_INTERNAL);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            internalFreq <= RST_INT_FREQ;
            storedFreq   <= RST_INT_FREQ;
            eepromWrite  <= 1'b0;
            eepromData   <= RST_INT_FREQ;
        end else begin
            eepromWrite <= 1'b0;
            if (hitW && awAddr == OFS_INT_FREQ) begin
                internalFreq <= clampFreq(wordNow);
                storedFreq   <= clampFreq(wordNow);
            end else if (adjustEnabled && enterPress) begin
                storedFreq  <= internalFreq;
                eepromWrite <= 1'b1;
                eepromData  <= internalFreq;
            end else if (adjustEnabled && escPress) begin
                internalFreq <= storedFreq;
            end else if (adjustEnabled && upPress && internalFreq < FREQ_MAX) begin
                internalFreq <= internalFreq + 12'h001;
            end else if (adjustEnabled && downPress && internalFreq != '0) begin
                internalFreq <= internalFreq - 12'h001;
            end else if (tick && raiseOn && !lowerOn && internalFreq < FREQ_MAX) begin
                internalFreq <= internalFreq + 12'h001;
            end else if (tick && lowerOn && !raiseOn && internalFreq != '0) begin
                internalFreq <= internalFreq - 12'h001;
            end
        end
    end

    // command source and ramp pair
    logic [FW-1:0] next_freqCommand;
    logic [TW-1:0] next_accelTime;
    logic [TW-1:0] next_decelTime;
    logic [1:0]    next_source;
    logic          useRamp2;
    always_comb begin
        useRamp2 = altRampOn;
        if (jogOn) begin
            next_freqCommand = (jogFreq > maxFreq) ? maxFreq : jogFreq;
            next_source      = SRC_JOG;
        end else if (presetOn) begin
            next_freqCommand = presetFreq[presetIdx];
            next_source      = SRC_PRESET;
            useRamp2         = altRampOn | presetIdx[1];
        end else if (speedRefSel == SEL_PRESET_LOW) begin
            next_freqCommand = presetFreq[0];
            next_source      = SRC_PRESET;
        end else if (speedRefSel == SEL_INTERNAL || mopConfigured) begin
            next_freqCommand = internalFreq;
            next_source      = SRC_INTERNAL;
        end else begin
            next_freqCommand = clampFreq(32'(extFreqRef));
            next_source      = SRC_EXT;
        end
        if (jogOn) begin
            next_accelTime = jogRamp;
            next_decelTime = jogRamp;
        end else if (useRamp2) begin
            next_accelTime = accel2;
            next_decelTime = decel2;
        end else begin
            next_accelTime = accel1;
            next_decelTime = decel1;
        end
    end

    logic [1:0] source;
    logic       rampPair2;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            freqCommand <= RST_INT_FREQ;
            accelTime   <= RST_RAMP1;
            decelTime   <= RST_RAMP1;
            jogActive   <= 1'b0;
            source      <= SRC_INTERNAL;
            rampPair2   <= 1'b0;
        end else begin
            freqCommand <= next_freqCommand;
            accelTime   <= next_accelTime;
            decelTime   <= next_decelTime;
            jogActive   <= jogOn;
            source      <= next_source;
            rampPair2   <= useRamp2 & ~jogOn;
        end
    end

    // brake injection timer in 0.1 s steps
    logic [9:0] brakeCount;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            brakeCount    <= '0;
            dcBrakeActive <= 1'b0;
        end else if (!brakeReq || dcBrakeDuration == '0) begin
            brakeCount    <= '0;
            dcBrakeActive <= 1'b0;
        end else if (brakeRise) begin
            brakeCount    <= '0;
            dcBrakeActive <= 1'b1;
        end else if (dcBrakeActive && dcBrakeDuration != DCB_CONT && tick) begin
            brakeCount <= brakeCount + 10'h001;
            if (brakeCount + 10'h001 >= dcBrakeDuration) begin
                dcBrakeActive <= 1'b0;
            end
        end
    end

    // read channel
    assign statusWord = {11'h0, dcBrakeActive, jogActive, rampPair2, source, 4'h0, freqCommand};
    assign readWord   = regWord(s_axi_araddr);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= mapped(s_axi_araddr) ? readWord : 32'h0;
                s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// File: tb/freq_ref_monitor.sv
// port assertions for the frequency reference selector
// assumes clk_sys and a synchronous active-high rst
`timescale 1ns/100ps
module freq_ref_monitor (
    input wire logic                        clk_sys,
    input wire logic                        rst,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [31:0]                 s_axi_rdata,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic [freq_ref_pkg::FW-1:0] freqCommand,
    input wire logic [freq_ref_pkg::TW-1:0] accelTime,
    input wire logic [freq_ref_pkg::TW-1:0] decelTime,
    input wire logic                        jogActive,
    input wire logic                        eepromWrite,
    input wire logic [freq_ref_pkg::FW-1:0] eepromData
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_busy_no_take: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_commit_pulse: assert property ($rose(eepromWrite) |=> !eepromWrite && $stable(eepromData))
        else $error("store pulse too long");
    a_jog_ramp: assert property (jogActive && $past(jogActive) |-> accelTime == decelTime)
        else $error("jog ramp times differ");
    a_freq_clamp: assert property (freqCommand <= 12'hFA0)
        else $error("command above limit");
endmodule
bind frequency_reference_selector freq_ref_monitor i_freq_ref_monitor (.*);

// File: tb/keypad_terminal_model.sv
// keypad and input terminal model driving the selector pins
// assumes the caller starts each task just after a rising edge
`timescale 1ns/100ps
module keypad_terminal_model (
    input  wire logic clk_sys,
    output logic [3:0] digitalIn,
    output logic       keyUp,
    output logic       keyDown,
    output logic       keyEnter,
    output logic       keyEsc,
    output logic       programMode,
    output logic       dcBrakeReq
);
    initial begin
        {digitalIn, keyUp, keyDown, keyEnter, keyEsc, programMode, dcBrakeReq} = '0;
    end
    // keys held long enough for the synchronizer to see one press
    task automatic press(input int k);
        case (k)
            0: keyUp <= 1'h1;
            1: keyDown <= 1'h1;
            2: keyEnter <= 1'h1;
            default: keyEsc <= 1'h1;
        endcase
        repeat (4) @(posedge clk_sys);
        {keyUp, keyDown, keyEnter, keyEsc} <= 4'h0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic setPins(input logic [3:0] d, input logic p, input logic b);
        digitalIn <= d;
        programMode <= p;
        dcBrakeReq <= b;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

// File: tb/frequency_reference_selector_tb.sv
// self-checking bench for the frequency reference selector
// assumes the bound monitor and the keypad terminal model
`timescale 1ns/100ps
module frequency_reference_selector_tb;
    import freq_ref_pkg::*;
    logic clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, keyUp, keyDown, keyEnter, keyEsc;
    logic programMode, dcBrakeReq, jogActive, eepromWrite, dcBrakeActive;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb, digitalIn;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [FW-1:0] extFreqRef, freqCommand, eepromData, seenData;
    logic [TW-1:0] accelTime, decelTime;
    int failures, total_checks;
    frequency_reference_selector #(.TICK_CYCLES(10)) i_frequency_reference_selector (.*);
    keypad_terminal_model i_keypad_terminal_model (.*);
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (eepromWrite === 1'h1) seenData <= eepromData;
    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic t_regs;
        check("reset cmd", freqCommand, 32'h258);
        rd(OFS_PRESET0 + 8'h04);
        check("preset1", rdv, 32'h32);
        rd(8'h54);
        check("bad addr", rsp, RESP_SLVERR);
        wr(OFS_INT_FREQ, 32'h1388);
        check("bresp", rsp, RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        wr(OFS_PRESET7, 32'h111);
        s_axi_wstrb <= 4'hF;
        rd(OFS_PRESET7);
        check("lanes", rdv, 32'h211);
        rd(OFS_INT_FREQ);
        check("clamp", rdv, 32'hFA0);
        check("int cmd", freqCommand, 32'hFA0);
    endtask
    task automatic t_keypad;
        wr(OFS_INT_FREQ, 32'h64);
        i_keypad_terminal_model.setPins(4'h0, 1'h1, 1'h0);
        i_keypad_terminal_model.press(0);
        check("up", freqCommand, 32'h65);
        i_keypad_terminal_model.press(2);
        check("store", seenData, 32'h65);
        i_keypad_terminal_model.press(0);
        i_keypad_terminal_model.press(1);
        i_keypad_terminal_model.press(0);
        check("up again", freqCommand, 32'h66);
        i_keypad_terminal_model.press(3);
        check("escape", freqCommand, 32'h65);
        i_keypad_terminal_model.setPins(4'h0, 1'h0, 1'h0);
    endtask
    task automatic t_preset;
        wr(OFS_DIN_FUNC, 32'h06040404);
        i_keypad_terminal_model.setPins(4'h6, 1'h0, 1'h0);
        check("preset6", freqCommand, 32'h1F4);
        check("pair2", accelTime, 32'hC8);
        i_keypad_terminal_model.setPins(4'h1, 1'h0, 1'h0);
        check("preset1", freqCommand, 32'h32);
        check("pair1", decelTime, 32'h64);
        i_keypad_terminal_model.setPins(4'h9, 1'h0, 1'h0);
        check("alt ramp", accelTime, 32'hC8);
        i_keypad_terminal_model.setPins(4'h0, 1'h0, 1'h0);
        check("no preset", freqCommand, 32'h65);
        wr(OFS_CTRL, 32'h4);
        check("preset0", freqCommand, 32'h0);
        wr(OFS_CTRL, 32'h0);
        check("external", freqCommand, 32'h12C);
        extFreqRef <= 12'hFFF;
    endtask
    task automatic t_jog;
        wr(OFS_DIN_FUNC, 32'h02040404);
        i_keypad_terminal_model.setPins(4'hE, 1'h0, 1'h0);
        check("jog", freqCommand, 32'h64);
        wr(OFS_JOG_RAMP, 32'h4D);
        check("jog acc", accelTime, 32'h4D);
        check("jog dec", decelTime, 32'h4D);
        wr(OFS_JOG_FREQ, 32'h3E8);
        check("jog limit", freqCommand, 32'h258);
        check("jog flag", jogActive, 32'h1);
        i_keypad_terminal_model.setPins(4'h0, 1'h0, 1'h0);
        check("ext clamp", freqCommand, 32'hFA0);
    endtask
    task automatic t_raise_brake;
        wr(OFS_DIN_FUNC, 32'h10000000);
        wr(OFS_CTRL, 32'h1);
        i_keypad_terminal_model.setPins(4'h8, 1'h0, 1'h0);
        repeat (40) @(posedge clk_sys);
        check("raise", freqCommand > 12'h065, 32'h1);
        wr(OFS_DCB_TIME, 32'h3);
        i_keypad_terminal_model.setPins(4'h0, 1'h0, 1'h1);
        check("brake on", dcBrakeActive, 32'h1);
        repeat (40) @(posedge clk_sys);
        check("brake off", dcBrakeActive, 32'h0);
        i_keypad_terminal_model.setPins(4'h0, 1'h0, 1'h0);
        wr(OFS_DCB_TIME, 32'h3E7);
        i_keypad_terminal_model.setPins(4'h0, 1'h0, 1'h1);
        repeat (60) @(posedge clk_sys);
        check("brake hold", dcBrakeActive, 32'h1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, seenData} = '0;
        s_axi_wstrb = 4'hF;
        extFreqRef = 12'h12C;
        rst = 1'h1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (2) @(posedge clk_sys);
        t_regs;
        t_keypad;
        t_preset;
        t_jog;
        t_raise_brake;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        report_and_stop;
    end
endmodule
